// [design/wac_pkg.sv]
package wac_pkg;

    // ------------------------------------------------------------
    // Widths and register addresses.
    // ------------------------------------------------------------
    localparam int         DATA_WIDTH          = 8;
    localparam int         ADDR_WIDTH          = 5;
    localparam int         NV_DEPTH            = 16;
    localparam int         NV_ADDR_WIDTH       = 4;
    localparam logic [4:0] ADDR_WIPER_A        = 5'h00;
    localparam logic [4:0] ADDR_WIPER_B        = 5'h01;
    localparam logic [4:0] ADDR_GP_FIRST       = 5'h02;
    localparam logic [4:0] ADDR_GP_LAST        = 5'h0e;
    localparam logic [4:0] ADDR_ACCESS_CONTROL = 5'h10;

    // ------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------
    localparam int         VOLATILE_ONLY_BIT    = 7;
    localparam int         SHUTDOWN_N_BIT       = 6;
    localparam int         NV_WRITE_BUSY_BIT    = 5;
    localparam logic [7:0] ACCESS_CONTROL_RESET = 8'h40;
    localparam logic [7:0] NV_FACTORY_VALUE     = 8'h80;
    localparam logic [7:0] NV_GP_FACTORY_VALUE  = 8'h00;

    // ------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS         = 8;
    localparam int NV_WRITE_TIME_NS        = 5000000;
    localparam int NV_WRITE_CYCLES_DEFAULT = (NV_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // ------------------------------------------------------------
    // Start-up sequencer states.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_ISSUE_A,
        ST_TAKE_A,
        ST_TAKE_B,
        ST_RUN
    } wac_state_type;

endpackage

// [design/wac_nv_store.sv]
`timescale 1ns/100ps
module wac_nv_store
    import wac_pkg::*;
#(
    parameter int WIDTH  = DATA_WIDTH,
    parameter int DEPTH  = NV_DEPTH,
    parameter int AWIDTH = NV_ADDR_WIDTH
) (
    input  wire logic              i_clock,
    input  wire logic              i_wr_en,
    input  wire logic [AWIDTH-1:0] i_wr_addr,
    input  wire logic [WIDTH-1:0]  i_wr_data,
    input  wire logic [AWIDTH-1:0] i_rd_addr,
    output logic      [WIDTH-1:0]  o_rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ------------------------------------------------------------
    // Stored contents keep their value through reset.
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = (i < 2) ? NV_FACTORY_VALUE : NV_GP_FACTORY_VALUE;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock) begin
        o_rd_data <= mem[i_rd_addr];
    end

endmodule // wac_nv_store

// [design/wac_access_control.sv]
`timescale 1ns/100ps
module wac_access_control
    import wac_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEFAULT
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_addr_load,
    input  wire logic [ADDR_WIDTH-1:0] i_addr,
    input  wire logic                  i_wr_en,
    input  wire logic [DATA_WIDTH-1:0] i_wr_data,
    input  wire logic                  i_rd_en,
    output logic      [DATA_WIDTH-1:0] o_rd_data,
    output logic                       o_rd_valid,
    output logic      [DATA_WIDTH-1:0] o_wiper_a,
    output logic      [DATA_WIDTH-1:0] o_wiper_b,
    output logic                       o_shutdown_n,
    output logic                       o_nv_write_busy,
    output logic                       o_ready
);

    localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

    logic                     rst_meta;
    logic                     rst_sync;
    wac_state_type            state;
    logic [ADDR_WIDTH-1:0]    ptr;
    logic                     volatile_only_select;
    logic [CNT_W-1:0]         busy_cnt;
    logic                     rd_pend;
    logic [ADDR_WIDTH-1:0]    rd_addr_q;
    logic [DATA_WIDTH-1:0]    mem_data;
    logic [NV_ADDR_WIDTH-1:0] mem_rd_addr;
    logic                     run;
    logic                     wr_take;
    logic                     rd_take;
    logic                     is_wiper;
    logic                     is_gp;
    logic                     nv_wr;
    logic                     wiper_wr;
    logic                     acr_wr;
    logic [DATA_WIDTH-1:0]    read_value;

    // ------------------------------------------------------------
    // Reset release.
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------
    assign run     = (state == ST_RUN);
    assign wr_take = i_wr_en && run;
    assign rd_take = i_rd_en && run;
    assign is_wiper = (ptr == ADDR_WIPER_A) || (ptr == ADDR_WIPER_B);
    assign is_gp    = (ptr >= ADDR_GP_FIRST) && (ptr <= ADDR_GP_LAST);
    assign nv_wr    = wr_take && !o_nv_write_busy && ((is_wiper && !volatile_only_select) || is_gp);
    assign wiper_wr = wr_take && !o_nv_write_busy && is_wiper;
    assign acr_wr   = wr_take && !o_nv_write_busy && (ptr == ADDR_ACCESS_CONTROL);

    always_comb begin
        unique case (state)
            ST_ISSUE_A: mem_rd_addr = ADDR_WIPER_A[NV_ADDR_WIDTH-1:0];
            ST_TAKE_A:  mem_rd_addr = ADDR_WIPER_B[NV_ADDR_WIDTH-1:0];
            ST_TAKE_B:  mem_rd_addr = ptr[NV_ADDR_WIDTH-1:0];
            ST_RUN:     mem_rd_addr = ptr[NV_ADDR_WIDTH-1:0];
        endcase
    end

    wac_nv_store u_nv_store (
        .i_clock   (i_clock),
        .i_wr_en   (nv_wr),
        .i_wr_addr (ptr[NV_ADDR_WIDTH-1:0]),
        .i_wr_data (i_wr_data),
        .i_rd_addr (mem_rd_addr),
        .o_rd_data (mem_data)
    );

    // ------------------------------------------------------------
    // Start-up load of the wipers.
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            state   <= ST_ISSUE_A;
            o_ready <= 1'b0;
        end else begin
            unique case (state)
                ST_ISSUE_A: state <= ST_TAKE_A;
                ST_TAKE_A:  state <= ST_TAKE_B;
                ST_TAKE_B:  state <= ST_RUN;
                ST_RUN:     state <= ST_RUN;
            endcase
            o_ready <= (state == ST_TAKE_B) || run;
        end
    end

    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            o_wiper_a <= NV_FACTORY_VALUE;
            o_wiper_b <= NV_FACTORY_VALUE;
        end else if (state == ST_TAKE_A) begin
            o_wiper_a <= mem_data;
        end else if (state == ST_TAKE_B) begin
            o_wiper_b <= mem_data;
        end else if (wiper_wr) begin
            if (ptr == ADDR_WIPER_A) begin
                o_wiper_a <= i_wr_data;
            end else begin
                o_wiper_b <= i_wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Access control register.
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            volatile_only_select <= ACCESS_CONTROL_RESET[VOLATILE_ONLY_BIT];
            o_shutdown_n         <= ACCESS_CONTROL_RESET[SHUTDOWN_N_BIT];
        end else if (acr_wr) begin
            volatile_only_select <= i_wr_data[VOLATILE_ONLY_BIT];
            o_shutdown_n         <= i_wr_data[SHUTDOWN_N_BIT];
        end
    end

    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            o_nv_write_busy <= 1'b0;
            busy_cnt        <= '0;
        end else if (nv_wr) begin
            o_nv_write_busy <= 1'b1;
            busy_cnt        <= CNT_W'(NV_WRITE_CYCLES - 1);
        end else if (o_nv_write_busy) begin
            if (busy_cnt == '0) begin
                o_nv_write_busy <= 1'b0;
            end else begin
                busy_cnt <= busy_cnt - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register pointer.
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            ptr <= ADDR_WIPER_A;
        end else if (i_addr_load) begin
            ptr <= i_addr;
        end else if (wr_take || rd_take) begin
            ptr <= (ptr == ADDR_ACCESS_CONTROL) ? ADDR_WIPER_A : ptr + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------
    always_comb begin
        read_value = '0;
        if (rd_addr_q == ADDR_WIPER_A) begin
            read_value = volatile_only_select ? o_wiper_a : mem_data;
        end else if (rd_addr_q == ADDR_WIPER_B) begin
            read_value = volatile_only_select ? o_wiper_b : mem_data;
        end else if ((rd_addr_q >= ADDR_GP_FIRST) && (rd_addr_q <= ADDR_GP_LAST)) begin
            read_value = mem_data;
        end else if (rd_addr_q == ADDR_ACCESS_CONTROL) begin
            read_value = {volatile_only_select, o_shutdown_n, o_nv_write_busy, 5'h00};
        end
    end

    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            rd_pend    <= 1'b0;
            rd_addr_q  <= '0;
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end else begin
            rd_pend    <= rd_take;
            rd_addr_q  <= ptr;
            o_rd_valid <= rd_pend;
            if (rd_pend) begin
                o_rd_data <= read_value;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_sync);

    property p_reset_value;
        (state == ST_ISSUE_A) |-> (o_shutdown_n && !volatile_only_select && !o_nv_write_busy);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("Access control not at reset value.");

    property p_nv_write_both;
        (nv_wr && (ptr == ADDR_WIPER_A)) |=> (o_wiper_a == $past(i_wr_data)) && o_nv_write_busy;
    endproperty
    a_nv_write_both: assert property (p_nv_write_both) else $error("Wiper A missed an initial value write.");

    property p_nv_read;
        (rd_pend && (rd_addr_q == ADDR_WIPER_B) && !volatile_only_select) |=> (o_rd_data == $past(mem_data));
    endproperty
    a_nv_read: assert property (p_nv_read) else $error("Wiper B read did not return stored value.");

    property p_volatile_only;
        (wr_take && volatile_only_select && is_wiper && !o_nv_write_busy) |=> !o_nv_write_busy;
    endproperty
    a_volatile_only: assert property (p_volatile_only) else $error("Storage written in volatile only mode.");

    property p_volatile_read;
        (rd_pend && (rd_addr_q == ADDR_WIPER_A) && volatile_only_select) |=> (o_rd_data == $past(o_wiper_a));
    endproperty
    a_volatile_read: assert property (p_volatile_read) else $error("Wiper A read did not return wiper.");

    property p_shutdown;
        acr_wr |=> (o_shutdown_n == $past(i_wr_data[SHUTDOWN_N_BIT]));
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("Shutdown control not taken.");

    property p_busy_ends;
        (o_nv_write_busy && (busy_cnt == '0) && !nv_wr) |=> !o_nv_write_busy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("Busy flag held too long.");

    property p_busy_blocks;
        (o_nv_write_busy && i_wr_en) |=> $stable(o_wiper_a) && $stable(o_wiper_b) && $stable(o_shutdown_n);
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("Write accepted while busy.");

    property p_load_b;
        (state == ST_TAKE_B) |=> (o_wiper_b == $past(mem_data)) && run;
    endproperty
    a_load_b: assert property (p_load_b) else $error("Wiper B not loaded at start-up.");

    property p_wrap;
        ((ptr == ADDR_ACCESS_CONTROL) && (wr_take || rd_take) && !i_addr_load) |=> (ptr == ADDR_WIPER_A);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Pointer did not wrap.");

    property p_low_zero;
        (rd_pend && (rd_addr_q == ADDR_ACCESS_CONTROL)) |=> (o_rd_data[4:0] == 5'h00);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("Access control low bits not zero.");

    c_nv_write: cover property (nv_wr ##1 o_nv_write_busy);
    c_wrap: cover property ((ptr == ADDR_ACCESS_CONTROL) && wr_take ##1 (ptr == ADDR_WIPER_A));
    c_refused: cover property (o_nv_write_busy && i_wr_en && is_wiper);
    c_vol_read: cover property (rd_pend && volatile_only_select && (rd_addr_q == ADDR_WIPER_B));

endmodule // wac_access_control

// [verification/wac_host_model.sv]
`timescale 1ns/100ps
module wac_host_model
    import wac_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic [DATA_WIDTH-1:0] i_rd_data,
    input  wire logic                  i_rd_valid,
    input  wire logic                  i_nv_write_busy,
    output logic                       o_addr_load,
    output logic      [ADDR_WIDTH-1:0] o_addr,
    output logic                       o_wr_en,
    output logic      [DATA_WIDTH-1:0] o_wr_data,
    output logic                       o_rd_en
);

    // ------------------------------------------------------------
    // Request tasks, entered and left at a falling edge.
    // ------------------------------------------------------------
    initial begin
        o_addr_load = 1'b0;
        o_addr      = 5'h00;
        o_wr_en     = 1'b0;
        o_wr_data   = 8'h00;
        o_rd_en     = 1'b0;
    end

    task automatic load(input logic [ADDR_WIDTH-1:0] addr);
        o_addr_load = 1'b1;
        o_addr      = addr;
        @(negedge i_clock);
        o_addr_load = 1'b0;
        o_addr      = ~addr;
    endtask

    task automatic write_byte(input logic [DATA_WIDTH-1:0] data);
        o_wr_en   = 1'b1;
        o_wr_data = data;
        @(negedge i_clock);
        o_wr_en   = 1'b0;
        o_wr_data = ~data;
        @(negedge i_clock);
    endtask

    // A missing answer comes back as unknown so the caller's compare fails.
    task automatic read_byte(output logic [DATA_WIDTH-1:0] data);
        data    = 8'hxx;
        o_rd_en = 1'b1;
        @(negedge i_clock);
        o_rd_en = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge i_clock);
            if (i_rd_valid === 1'b1) begin
                data = i_rd_data;
                break;
            end
        end
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 40 && i_nv_write_busy !== 1'b0; i++) begin
            @(negedge i_clock);
        end
    endtask

endmodule // wac_host_model

// [verification/wac_access_control_test.sv]
`timescale 1ns/100ps
module wac_access_control_test
    import wac_pkg::*;
;
    logic                  i_clock;
    logic                  i_rst_b;
    logic                  addr_load;
    logic [ADDR_WIDTH-1:0] addr;
    logic                  wr_en;
    logic [DATA_WIDTH-1:0] wr_data;
    logic                  rd_en;
    logic [DATA_WIDTH-1:0] rd_data;
    logic                  rd_valid;
    logic [DATA_WIDTH-1:0] wiper_a;
    logic [DATA_WIDTH-1:0] wiper_b;
    logic                  shutdown_n;
    logic                  busy;
    logic                  ready;
    logic [DATA_WIDTH-1:0] got;
    int                    bad_count;
    int                    num_checks;

    initial i_clock = 1'b0;
    always #4 i_clock = ~i_clock;

    wac_access_control #(.NV_WRITE_CYCLES(20)) dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr_load(addr_load), .i_addr(addr),
        .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_wiper_a(wiper_a), .o_wiper_b(wiper_b),
        .o_shutdown_n(shutdown_n), .o_nv_write_busy(busy), .o_ready(ready)
    );

    wac_host_model host (
        .i_clock(i_clock), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .i_nv_write_busy(busy),
        .o_addr_load(addr_load), .o_addr(addr), .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en)
    );

    // ------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.load(a);
        host.write_byte(d);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        host.load(a);
        host.read_byte(d);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_reset();
        check("wiper a", wiper_a, 8'h80);
        check("wiper b", wiper_b, 8'h80);
        check("shutdown", {7'h00, shutdown_n}, 8'h01);
        rd(5'h10, got);
        check("access control", got, 8'h40);
        rd(5'h0f, got);
        check("reserved", got, 8'h00);
    endtask

    task automatic t_nv_write();
        wr(5'h00, 8'h3c);
        check("wiper a", wiper_a, 8'h3c);
        check("busy", {7'h00, busy}, 8'h01);
        wr(5'h10, 8'h80);
        rd(5'h10, got);
        check("access control busy", got, 8'h60);
        wr(5'h01, 8'h77);
        check("wiper b refused", wiper_b, 8'h80);
        host.wait_idle();
        check("busy", {7'h00, busy}, 8'h00);
        rd(5'h10, got);
        check("access control idle", got, 8'h40);
        rd(5'h00, got);
        check("stored a", got, 8'h3c);
        rd(5'h01, got);
        check("stored b refused", got, 8'h80);
    endtask

    task automatic t_volatile();
        wr(5'h10, 8'hdf);
        host.write_byte(8'h11);
        check("busy", {7'h00, busy}, 8'h00);
        check("wiper a", wiper_a, 8'h11);
        rd(5'h10, got);
        check("access control", got, 8'hc0);
        host.read_byte(got);
        check("wiper a read", got, 8'h11);
        wr(5'h10, 8'h40);
        rd(5'h00, got);
        check("stored a", got, 8'h3c);
        check("wiper a", wiper_a, 8'h11);
    endtask

    task automatic t_shutdown_b();
        wr(5'h10, 8'h00);
        check("shutdown", {7'h00, shutdown_n}, 8'h00);
        wr(5'h10, 8'h40);
        check("shutdown", {7'h00, shutdown_n}, 8'h01);
        wr(5'h01, 8'h5a);
        check("wiper b", wiper_b, 8'h5a);
        check("wiper a", wiper_a, 8'h11);
        host.wait_idle();
        rd(5'h01, got);
        check("stored b", got, 8'h5a);
    endtask

    task automatic t_restart();
        wr(5'h05, 8'ha5);
        check("busy", {7'h00, busy}, 8'h01);
        host.wait_idle();
        i_rst_b = 1'b0;
        repeat (5) @(negedge i_clock);
        i_rst_b = 1'b1;
        for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
            @(negedge i_clock);
        end
        check("ready", {7'h00, ready}, 8'h01);
        check("wiper a", wiper_a, 8'h3c);
        check("wiper b", wiper_b, 8'h5a);
        rd(5'h10, got);
        check("access control", got, 8'h40);
        rd(5'h05, got);
        check("stored general", got, 8'ha5);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog.
    // ------------------------------------------------------------
    initial begin
        bad_count  = 0;
        num_checks = 0;
        i_rst_b    = 1'b0;
        repeat (5) @(negedge i_clock);
        i_rst_b = 1'b1;
        for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
            @(negedge i_clock);
        end
        check("ready", {7'h00, ready}, 8'h01);
        t_reset();
        t_nv_write();
        t_volatile();
        t_shutdown_b();
        t_restart();
        report_and_stop();
    end

    initial begin
        #24000;
        bad_count++;
        report_and_stop();
    end

endmodule // wac_access_control_test
